// ==== hdl/dis_ctrl.sv ====
// Purpose: Host-side sequencer bringing a DDR2 controller out of cold reset.
// Assumes: Software orders it over AHB-Lite; device reached by word port.
// Notes:   Device start bits at DEV_CFGLO_OFS self-clear when its sequence has finished; init enable is cleared by a write.
`timescale 1ns/1ps
`default_nettype none
module dis_ctrl #(
  parameter int SREX_RG_CYC = dis_pkg::SREX_RG_CYC,
  parameter int SW_INIT_CYC = dis_pkg::SW_INIT_CYC
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Device register port
  output dis_pkg::dis_dev_req_t      dev_req,
  input  wire dis_pkg::dis_dev_rsp_t dev_rsp,
  // System side
  output logic                       link_stop_n,
  output logic                       traffic_enable
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_W_ATIM, ST_W_DRV, ST_W_DUAL, ST_W_FREQ, ST_WAIT,
    ST_W_START, ST_POLL, ST_SW_HOLD, ST_W_CLR, ST_READY, ST_FAULT
  } dis_st_t;

  typedef struct packed {
    dis_st_t               st;
    logic                  issued;
    logic [31:0]           ctrl;
    logic [31:0]           atim;
    logic [31:0]           drv;
    logic                  two_t;
    logic                  unsup;
    logic [7:0]            daddr;
    logic                  dwe;
    logic [31:0]           ddata;
    logic                  dpend;
    logic                  ph_act;
    logic                  ph_wr;
    logic [2:0]            ph_idx;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  link_stop_n;
    logic                  traffic;
    logic                  tstart;
    logic [15:0]           tval;
    logic                  cmd_valid;
    dis_pkg::dis_dev_req_t cmd;
  } dis_ctrl_t;
  dis_ctrl_t s, next_s;

  logic        dev_done;
  logic [31:0] dev_rdata;
  logic        t_expired;

  // Recommended timing lookup: {unsupported, two-cycle, address timing}
  function automatic logic [33:0] lut(input logic [1:0] sys, input logic [1:0] spd,
                                      input logic [1:0] rnk, input logic x8);
    logic [33:0] r;
    r = {2'b10, 32'h0000_0000};
    case (sys)
      dis_pkg::SYS_SODIMM: begin
        if (spd == dis_pkg::SPD_400 && rnk != dis_pkg::RNK_QR) begin
          r = {2'b00, dis_pkg::ATIM_2F2F};
        end else if (spd == dis_pkg::SPD_533 && rnk != dis_pkg::RNK_QR) begin
          r = {2'b00, (rnk == dis_pkg::RNK_DR && x8) ? dis_pkg::ATIM_2C2C : dis_pkg::ATIM_2F2F};
        end else if (spd == dis_pkg::SPD_667 && rnk == dis_pkg::RNK_SR) begin
          r = {2'b00, x8 ? dis_pkg::ATIM_2424 : dis_pkg::ATIM_2727};
        end else if (spd == dis_pkg::SPD_667 && rnk == dis_pkg::RNK_DR) begin
          r = x8 ? {2'b01, dis_pkg::ATIM_0028} : {2'b00, dis_pkg::ATIM_2A2A};
        end
      end
      dis_pkg::SYS_RDIMM4: begin
        if (spd == dis_pkg::SPD_400 && rnk != 2'h3) begin
          r = {2'b00, (rnk == dis_pkg::RNK_QR) ? dis_pkg::ATIM_2F27 : dis_pkg::ATIM_2F00};
        end else if (spd == dis_pkg::SPD_533 && rnk != 2'h3) begin
          r = {2'b00, dis_pkg::ATIM_2F27};
        end else if (spd == dis_pkg::SPD_667 && rnk == dis_pkg::RNK_SR) begin
          r = {2'b00, dis_pkg::ATIM_2F00};
        end else if (spd == dis_pkg::SPD_667 && rnk == dis_pkg::RNK_DR) begin
          r = {2'b00, dis_pkg::ATIM_2F2F};
        end
      end
      dis_pkg::SYS_RDIMM8: begin
        if (rnk == dis_pkg::RNK_SR || rnk == dis_pkg::RNK_DR) begin
          if (spd == dis_pkg::SPD_533) begin
            r = {2'b00, dis_pkg::ATIM_3200};
          end else if (spd == dis_pkg::SPD_400 || spd == dis_pkg::SPD_667) begin
            r = {2'b00, dis_pkg::ATIM_2F00};
          end
        end
      end
      default: r = {2'b10, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // Register access, sequencing and device command selection
  always_comb begin
    logic        go;
    logic        swdone;
    logic        devgo;
    logic        want;
    logic [7:0]  c_addr;
    logic        c_we;
    logic [31:0] c_data;
    dis_st_t     c_next;
    logic [33:0] pick;
    logic        busy;
    go = 1'b0;
    swdone = 1'b0;
    devgo = 1'b0;
    want = 1'b0;
    c_addr = 8'h00;
    c_we = 1'b1;
    c_data = 32'h0000_0000;
    c_next = s.st;
    next_s = s;
    next_s.tstart = 1'b0;
    next_s.cmd_valid = 1'b0;
    next_s.hreadyout = 1'b1;
    busy = (s.st != ST_IDLE) && (s.st != ST_READY) && (s.st != ST_FAULT);
    pick = 34'h0;

    // Address phase: latch target, prepare read data
    next_s.ph_act = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      next_s.ph_wr = hwrite;
      next_s.ph_idx = haddr[4:2];
      case (haddr[4:2])
        dis_pkg::HREG_CTRL:   next_s.hrdata = s.ctrl;
        dis_pkg::HREG_STATUS: next_s.hrdata = {22'h0, s.st, s.dpend, s.unsup,
                                               s.two_t, s.link_stop_n, s.traffic, busy};
        dis_pkg::HREG_ATIM:   next_s.hrdata = s.atim;
        dis_pkg::HREG_DRV:    next_s.hrdata = s.drv;
        dis_pkg::HREG_DCMD:   next_s.hrdata = {23'h000000, s.dwe, s.daddr};
        dis_pkg::HREG_DDATA:  next_s.hrdata = s.ddata;
        default:              next_s.hrdata = 32'h0000_0000;
      endcase
    end

    // Data phase writes
    if (s.ph_act && s.ph_wr) begin
      case (s.ph_idx)
        dis_pkg::HREG_CTRL: begin
          next_s.ctrl = hwdata & dis_pkg::CTRL_KEEP_MASK;
          go = hwdata[dis_pkg::CTRL_GO];
          swdone = hwdata[dis_pkg::CTRL_SWDONE];
        end
        dis_pkg::HREG_DCMD: begin
          next_s.daddr = hwdata[7:0];
          next_s.dwe = hwdata[8];
          devgo = 1'b1;
        end
        dis_pkg::HREG_DDATA: next_s.ddata = hwdata;
        default: ;
      endcase
    end

    // Lookup sees the population written together with GO
    pick = lut(next_s.ctrl[11:10], next_s.ctrl[9:8], next_s.ctrl[13:12], next_s.ctrl[14]);

    // Sequencer
    case (s.st)
      ST_IDLE, ST_READY, ST_FAULT: begin
        if (go && s.st == ST_IDLE) begin
          next_s.atim = pick[31:0];
          next_s.drv = dis_pkg::DRV_1T;
          next_s.two_t = pick[32];
          next_s.unsup = pick[33];
          next_s.st = pick[33] ? ST_FAULT : ST_W_ATIM;
        end
      end
      ST_W_ATIM: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_ATIM_OFS;
        c_data = s.atim;
        c_next = ST_W_DRV;
      end
      ST_W_DRV: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_DRV_OFS;
        c_data = s.drv;
        c_next = ST_W_DUAL;
      end
      ST_W_DUAL: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_DUAL_OFS;
        c_data[dis_pkg::DUAL_BIT] = s.ctrl[4];
        c_next = ST_W_FREQ;
      end
      ST_W_FREQ: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_CFGHI_OFS;
        c_data[dis_pkg::CFGHI_FREQ_BIT] = 1'b1;
        c_data[dis_pkg::CFGHI_2T_BIT] = s.two_t;
        c_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (t_expired) begin
          next_s.st = ST_W_START;
        end
      end
      ST_W_START: begin
        want = 1'b1;
        if (s.ctrl[2:1] == dis_pkg::MODE_SW) begin
          c_addr = dis_pkg::DEV_INIT_OFS;
          c_data[dis_pkg::INIT_EN_BIT] = 1'b1;
          c_next = ST_SW_HOLD;
        end else begin
          c_addr = dis_pkg::DEV_CFGLO_OFS;
          c_data[dis_pkg::CFGLO_INIT_BIT] = (s.ctrl[2:1] == dis_pkg::MODE_HW);
          c_data[dis_pkg::CFGLO_SREX_BIT] = (s.ctrl[2:1] == dis_pkg::MODE_SREX);
          c_next = ST_POLL;
        end
      end
      ST_POLL: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_CFGLO_OFS;
        c_we = 1'b0;
        c_next = ST_POLL;
        if (s.issued && dev_done && dev_rdata[1:0] == 2'b00) begin
          c_next = ST_READY;
        end
      end
      ST_SW_HOLD: begin
        if (devgo && !s.dpend) begin
          next_s.dpend = 1'b1;
          next_s.cmd_valid = 1'b1;
          next_s.cmd = '{req: 1'b1, we: hwdata[8], addr: hwdata[7:0], wdata: s.ddata};
        end
        if (s.dpend && dev_done) begin
          next_s.dpend = 1'b0;
          next_s.ddata = dev_rdata;
        end
        if (swdone && !s.dpend) begin
          next_s.st = ST_W_CLR;
        end
      end
      ST_W_CLR: begin
        want = 1'b1;
        c_addr = dis_pkg::DEV_INIT_OFS;
        c_next = ST_READY;
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Common device command issue and completion
    if (want) begin
      if (!s.issued) begin
        next_s.issued = 1'b1;
        next_s.cmd_valid = 1'b1;
        next_s.cmd = '{req: 1'b1, we: c_we, addr: c_addr, wdata: c_data};
      end else if (dev_done) begin
        next_s.issued = 1'b0;
        next_s.st = c_next;
        if (c_next == ST_WAIT) begin
          next_s.tstart = 1'b1;
          if (s.ctrl[2:1] == dis_pkg::MODE_HW) begin
            next_s.tval = 16'(dis_pkg::FREQ_START_CYC);
          end else if (s.ctrl[2:1] == dis_pkg::MODE_SREX) begin
            next_s.tval = s.ctrl[3] ? 16'(SREX_RG_CYC) : 16'(dis_pkg::SREX_UB_CYC);
          end else begin
            next_s.tval = 16'(SW_INIT_CYC);
          end
        end
      end
    end

    // link stop held off during init
    next_s.link_stop_n = !(s.ctrl[5] && !(next_s.st inside {ST_W_START, ST_POLL,
                                                             ST_SW_HOLD, ST_W_CLR}));
    next_s.traffic = (next_s.st == ST_READY);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= dis_pkg::CTRL_RESET;
      s.link_stop_n <= 1'b1;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Wait timer
  dis_wait_timer u_timer (
    .clock    (clock),
    .nrst     (nrst),
    .start    (s.tstart),
    .load_val (s.tval),
    .expired  (t_expired)
  );

  // Device word port
  dis_dev_port u_port (
    .clock     (clock),
    .nrst      (nrst),
    .cmd_valid (s.cmd_valid),
    .cmd       (s.cmd),
    .done      (dev_done),
    .rdata     (dev_rdata),
    .dev_req   (dev_req),
    .dev_rsp   (dev_rsp)
  );

  // Registered outputs; hresp tied to OKAY
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign link_stop_n = s.link_stop_n;
  assign traffic_enable = s.traffic;
endmodule
`default_nettype wire

// ==== hdl/dis_dev_port.sv ====
// Purpose: Issues one word access at a time on the device register port.
// Assumes: Device answers with a one-cycle ack while req is high.
// Notes:   Accepts a new command only while idle.
`timescale 1ns/1ps
`default_nettype none
module dis_dev_port (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // Sequencer side
  input  wire logic                  cmd_valid,
  input  wire dis_pkg::dis_dev_req_t cmd,
  output logic                       done,
  output logic [31:0]                rdata,
  // Device side
  output dis_pkg::dis_dev_req_t      dev_req,
  input  wire dis_pkg::dis_dev_rsp_t dev_rsp
);
  typedef struct packed {
    dis_pkg::dis_dev_req_t bus;
    logic                  done;
    logic [31:0]           rdata;
  } dis_port_t;
  dis_port_t s, next_s;

  // Hold the request until the device acknowledges
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.bus.req && dev_rsp.ack) begin
      next_s.bus.req = 1'b0;
      next_s.done = 1'b1;
      next_s.rdata = dev_rsp.rdata;
    end else if (!s.bus.req && cmd_valid) begin
      next_s.bus = cmd;
      next_s.bus.req = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign rdata = s.rdata;
  assign dev_req = s.bus;
endmodule
`default_nettype wire

// ==== hdl/dis_pkg.sv ====
// Purpose: Shared constants and carriers for the DRAM start-up sequencer.
// Assumes: 125 MHz clock; device registers reached over a simple word port.
// Notes:   Notes on behaviour listed below.
package dis_pkg;
  // Device register offsets and bit positions
  localparam logic [7:0]  DEV_INIT_OFS     = 8'h7C;
  localparam logic [7:0]  DEV_CFGLO_OFS    = 8'h90;
  localparam logic [7:0]  DEV_CFGHI_OFS    = 8'h94;
  localparam logic [7:0]  DEV_DUAL_OFS     = 8'hA0;
  localparam logic [7:0]  DEV_ATIM_OFS     = 8'hE4;
  localparam logic [7:0]  DEV_DRV_OFS      = 8'hE0;
  localparam int          CFGLO_INIT_BIT   = 0;
  localparam int          CFGLO_SREX_BIT   = 1;
  localparam int          CFGHI_FREQ_BIT   = 3;
  localparam int          CFGHI_2T_BIT     = 20;
  localparam int          INIT_EN_BIT      = 31;
  localparam int          DUAL_BIT         = 4;
  // Host register word indices (byte address = 4 * index)
  localparam logic [2:0]  HREG_CTRL        = 3'h0;
  localparam logic [2:0]  HREG_STATUS      = 3'h1;
  localparam logic [2:0]  HREG_ATIM        = 3'h2;
  localparam logic [2:0]  HREG_DRV         = 3'h3;
  localparam logic [2:0]  HREG_DCMD        = 3'h4;
  localparam logic [2:0]  HREG_DDATA       = 3'h5;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] CTRL_KEEP_MASK   = 32'h0000_7FBE;
  localparam int          CTRL_GO          = 0;
  localparam int          CTRL_SWDONE      = 6;
  // Mode, system, speed and rank codes
  localparam logic [1:0]  MODE_HW = 2'h0, MODE_SREX = 2'h1, MODE_SW = 2'h2;
  localparam logic [1:0]  SYS_SODIMM = 2'h0, SYS_RDIMM4 = 2'h1, SYS_RDIMM8 = 2'h2;
  localparam logic [1:0]  SPD_400 = 2'h0, SPD_533 = 2'h1, SPD_667 = 2'h2;
  localparam logic [1:0]  RNK_SR = 2'h0, RNK_DR = 2'h1, RNK_QR = 2'h2;
  // Recommended address timing and drive values
  localparam logic [31:0] ATIM_2F2F = 32'h002F_2F00;
  localparam logic [31:0] ATIM_2C2C = 32'h002C_2C00;
  localparam logic [31:0] ATIM_2727 = 32'h0027_2700;
  localparam logic [31:0] ATIM_2424 = 32'h0024_2400;
  localparam logic [31:0] ATIM_2A2A = 32'h002A_2A00;
  localparam logic [31:0] ATIM_0028 = 32'h0000_2800;
  localparam logic [31:0] ATIM_2F00 = 32'h002F_0000;
  localparam logic [31:0] ATIM_2F27 = 32'h002F_2700;
  localparam logic [31:0] ATIM_3200 = 32'h0032_0000;
  localparam logic [31:0] DRV_1T    = 32'h0011_1222;
  // Wait times in ns and derived cycle counts (rounded up); frequency start wait given directly in cycles
  localparam int          CLK_NS        = 8;
  localparam int          FREQ_START_CYC = 20;
  localparam int          SREX_UB_NS    = 10000;
  localparam int          SREX_RG_NS    = 100000;
  localparam int          SW_INIT_NS    = 200000;
  localparam int          SREX_UB_CYC   = (SREX_UB_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SREX_RG_CYC   = (SREX_RG_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SW_INIT_CYC   = (SW_INIT_NS + CLK_NS - 1) / CLK_NS;
  // Device word port carriers
  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dis_dev_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } dis_dev_rsp_t;
endpackage

// ==== hdl/dis_wait_timer.sv ====
// Purpose: Down-counter that flags when a programmed wait has run out.
// Assumes: start is a one-cycle pulse from the sequencer.
// Notes:   expired is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module dis_wait_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Control
  input  wire logic        start,
  input  wire logic [15:0] load_val,
  output logic             expired
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        fin;
  } dis_tmr_t;
  dis_tmr_t s, next_s;

  // Count down once loaded, pulse at the end
  always_comb begin
    next_s = s;
    next_s.fin = 1'b0;
    if (start) begin
      next_s.cnt = load_val;
      next_s.run = 1'b1;
    end else if (s.run) begin
      if (s.cnt <= 16'h0001) begin
        next_s.run = 1'b0;
        next_s.fin = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired = s.fin;
endmodule
`default_nettype wire

// ==== test/dis_ctrl_asserts.sv ====
// Purpose: Port checks for the DRAM start-up sequencer.
// Assumes: One clock domain; device ack is a one-cycle pulse.
// Notes:   Bound to every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module dis_ctrl_asserts #(
  parameter int SREX_RG_CYC = dis_pkg::SREX_RG_CYC,
  parameter int SW_INIT_CYC = dis_pkg::SW_INIT_CYC
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  nrst,
  // AHB-Lite slave
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  // Device port and system side
  input wire dis_pkg::dis_dev_req_t dev_req,
  input wire dis_pkg::dis_dev_rsp_t dev_rsp,
  input wire logic                  link_stop_n,
  input wire logic                  traffic_enable
);
  localparam int         SRX_MIN = (SREX_RG_CYC < dis_pkg::SREX_UB_CYC) ? SREX_RG_CYC : dis_pkg::SREX_UB_CYC;
  localparam logic [7:0] LO      = dis_pkg::DEV_CFGLO_OFS;
  localparam logic [7:0] IN      = dis_pkg::DEV_INIT_OFS;
  logic [15:0] cnt;
  logic        armed;
  logic        hw_go;
  logic [1:0]  st;
  wire logic   ack = dev_req.req && dev_rsp.ack;
  wire logic   wr  = ack && dev_req.we;
  // Cycles since frequency valid, start and completion tracking
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      armed <= 1'b0;
      hw_go <= 1'b0;
      st <= 2'h0;
    end else begin
      if (cnt != 16'hFFFF) cnt <= cnt + 16'h1;
      if (wr && dev_req.addr == dis_pkg::DEV_CFGHI_OFS && dev_req.wdata[dis_pkg::CFGHI_FREQ_BIT]) begin
        armed <= 1'b1;
        cnt <= '0;
      end
      if (wr && dev_req.addr == LO && dev_req.wdata[1:0] != 2'h0) begin
        hw_go <= 1'b1;
        st <= 2'h1;
      end
      if (wr && dev_req.addr == IN && dev_req.wdata[31]) st <= 2'h1;
      if (ack && st == 2'h1 && ((!dev_req.we && dev_req.addr == LO && dev_rsp.rdata[1:0] == 2'h0)
          || (dev_req.we && dev_req.addr == IN && !dev_req.wdata[31]))) st <= 2'h2;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  a_no_wait: assert property (hreadyout == 1'b1) else $error("wait state inserted");
  a_req_hold: assert property (dev_req.req && !dev_rsp.ack |=> dev_req.req && $stable(dev_req))
    else $error("device request changed before ack");
  a_req_release: assert property (ack |=> !dev_req.req ##1 !dev_req.req)
    else $error("device request not released");
  a_init_wait: assert property (dev_req.req && dev_req.we && dev_req.addr == LO && dev_req.wdata[0]
    |-> armed && cnt >= dis_pkg::FREQ_START_CYC) else $error("init start too early");
  a_srex_wait: assert property (dev_req.req && dev_req.we && dev_req.addr == LO && dev_req.wdata[1]
    |-> armed && cnt >= SRX_MIN) else $error("self-refresh exit too early");
  a_swinit_wait: assert property (dev_req.req && dev_req.we && dev_req.addr == IN && dev_req.wdata[31]
    |-> armed && cnt >= SW_INIT_CYC) else $error("software init enable too early");
  a_start_last: assert property (hw_go && dev_req.req |-> !dev_req.we)
    else $error("configuration write after start");
  a_link_quiet: assert property (dev_req.req && (dev_req.addr == LO || dev_req.addr == IN) |-> link_stop_n)
    else $error("link stop while start pending");
  a_traffic_gate: assert property (traffic_enable |-> st == 2'h2)
    else $error("traffic before sequence end");
endmodule
bind dis_ctrl dis_ctrl_asserts #(.SREX_RG_CYC(SREX_RG_CYC), .SW_INIT_CYC(SW_INIT_CYC)) dis_ctrl_asserts_i (
  .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_req(dev_req),
  .dev_rsp(dev_rsp), .link_stop_n(link_stop_n), .traffic_enable(traffic_enable));
`default_nettype wire

// ==== test/dis_dev_model.sv ====
// Purpose: Behavioural memory controller register file on the word port.
// Assumes: Ack may come at once or after a few cycles.
// Notes:   Start bits at 0x90 self-clear ten cycles after being set.
`timescale 1ns/1ps
`default_nettype none
module dis_dev_model (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // Device register port
  input  wire dis_pkg::dis_dev_req_t dev_req,
  output dis_pkg::dis_dev_rsp_t      dev_rsp,
  // Answer speed
  input  wire logic                  slow
);
  logic [31:0] mem [0:63];
  logic [2:0]  dly;
  logic [3:0]  busy;
  // Register file, ack timing and sequence completion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dev_rsp <= '0;
      dly <= '0;
      busy <= '0;
      for (int i = 0; i < 64; i++) mem[i] <= '0;
    end else begin
      dev_rsp.ack <= 1'b0;
      dev_rsp.rdata <= ~dev_rsp.rdata; // Stale data alternates with its inverse until the next ack
      if (busy == 4'h1) mem[6'h24][1:0] <= 2'h0;
      if (busy != 4'h0) busy <= busy - 4'h1;
      if (dev_req.req && !dev_rsp.ack) begin
        dly <= dly + 3'h1;
        if (!slow || dly == 3'h3) begin
          dly <= 3'h0;
          dev_rsp.ack <= 1'b1;
          dev_rsp.rdata <= mem[dev_req.addr[7:2]];
          if (dev_req.we) mem[dev_req.addr[7:2]] <= dev_req.wdata;
          if (dev_req.we && dev_req.addr == 8'h90 && dev_req.wdata[1:0] != 2'h0) busy <= 4'hA;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/test_dis_ctrl.sv ====
// Purpose: Self-checking bench for the DRAM start-up sequencer.
// Assumes: Short wait parameters; device modelled behaviourally.
// Notes:   Each population runs from its own reset.
`timescale 1ns/1ps
`default_nettype none
module test_dis_ctrl;
  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  logic                  hsel = 1'b0;
  logic                  hwrite = 1'b0;
  logic                  slow = 1'b0;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           haddr = 32'h0;
  logic [31:0]           hwdata = 32'h0;
  logic [31:0]           hrdata;
  logic [31:0]           rd;
  logic                  hreadyout;
  logic                  hresp;
  logic                  link_stop_n;
  logic                  traffic_enable;
  dis_pkg::dis_dev_req_t dev_req;
  dis_pkg::dis_dev_rsp_t dev_rsp;
  int                    err_total = 0;
  int                    n_tests = 0;
  logic [31:0]           cfg [0:7] = '{32'h0929, 32'h080B, 32'h1629, 32'h0609, 32'h2409, 32'h5113, 32'h5201, 32'h2609};
  logic [31:0]           atim [0:7] = '{32'h0032_0000, 32'h002F_0000, 32'h002F_2F00, 32'h002F_0000,
                                        32'h002F_2700, 32'h002C_2C00, 32'h0000_2800, 32'h0};
  // Clock
  always #4 clock = ~clock;
  dis_ctrl #(.SREX_RG_CYC(30), .SW_INIT_CYC(40)) dis_ctrl_i (.clock(clock), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_req(dev_req), .dev_rsp(dev_rsp),
    .link_stop_n(link_stop_n), .traffic_enable(traffic_enable));
  dis_dev_model dis_dev_model_i (.clock(clock), .nrst(nrst), .dev_req(dev_req), .dev_rsp(dev_rsp), .slow(slow));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One single AHB word transfer
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      xfer(32'h4, 1'b0, 32'h0);
      k++;
    end while ((rd & m) !== v && k < 3000);
    chk(rd & m, v);
  endtask
  task automatic rst();
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
  endtask
  function automatic logic [31:0] dm(input logic [7:0] a);
    return dis_dev_model_i.mem[a[7:2]];
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      rst();
      slow <= i[0];
      if (i == 0) begin
        xfer(32'h4, 1'b0, 32'h0);
        chk(rd & 32'h3FF, 32'h4);
        xfer(32'h18, 1'b1, 32'hFFFF_FFFF);
        xfer(32'h18, 1'b0, 32'h0);
        chk(rd, 32'h0);
      end
      xfer(32'h0, 1'b1, cfg[i]);
      if (atim[i] == 32'h0) begin
        poll(32'h10, 32'h10);
        chk({31'h0, traffic_enable}, 32'h0);
        chk(dm(8'h90), 32'h0);
      end else begin
        poll(32'h2, 32'h2);
        xfer(32'h8, 1'b0, 32'h0);
        chk(rd, atim[i]);
        chk(dm(8'hE4), atim[i]);
        chk(dm(8'hE0), dis_pkg::DRV_1T);
        chk(dm(8'h94) & 32'h0010_0008, (atim[i] == 32'h0000_2800) ? 32'h0010_0008 : 32'h8);
        chk(dm(8'hA0) & 32'h10, cfg[i] & 32'h10);
        chk(dm(8'h90) & 32'h3, 32'h0);
        chk({31'h0, link_stop_n}, {31'h0, ~cfg[i][5]});
      end
      $display("test %0d done", i);
    end
    rst();
    xfer(32'h0, 1'b1, 32'h042D);
    poll(32'h3C0, 32'h200);
    chk(dm(8'h7C) & 32'h8000_0000, 32'h8000_0000);
    chk({31'h0, link_stop_n}, 32'h1);
    xfer(32'h14, 1'b1, 32'hA5C3_0F96);
    xfer(32'h10, 1'b1, 32'h0140);
    poll(32'h20, 32'h0);
    chk(dm(8'h40), 32'hA5C3_0F96);
    xfer(32'h14, 1'b1, 32'h0);
    xfer(32'h10, 1'b1, 32'h0040);
    poll(32'h20, 32'h0);
    xfer(32'h14, 1'b0, 32'h0);
    chk(rd, 32'hA5C3_0F96);
    chk({31'h0, traffic_enable}, 32'h0);
    xfer(32'h0, 1'b1, 32'h046C);
    poll(32'h2, 32'h2);
    chk(dm(8'h7C) & 32'h8000_0000, 32'h0);
    chk({31'h0, link_stop_n}, 32'h0);
    $display("test sw done");
    summarize();
  end
  // Watchdog cuts a hang short
  initial begin
    #400us;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
